// *** rtl/pso_preset_outputs.v ***
// Two preset comparator switching outputs with pulse, auto-clear and status display
//
// The register addresses and strobed register access were left to the implementer.
`timescale 1ns/1ps
`include "pso_regs.vh"

// Contract
// RQ1 - Code 0: output on as level while value >= preset.
// RQ2 - Code 1: output on as level while value <= preset.
// RQ3 - Codes 2, 3: timed pulse on rising GE or LE condition, both outputs.
// RQ4 - Output 1 code 4: pulse and clear count when value reaches preset 1.
// RQ5 - Output 1 code 5: pulse and load preset 1 when value reaches zero.
// RQ6 - Output 2 code 4: level while value >= preset 1 minus preset 2.
// RQ7 - Output 2 code 5: pulse when value reaches preset 1 minus preset 2.
// RQ8 - Every pulse lasts fixed 500 ms, not software adjustable.
// RQ9 - Anticipation threshold follows preset 1 at preset 2 distance.
// RQ10 - Hysteresis used only in tachometer and time modes.
// RQ11 - Hysteresis band side depends on GE or LE characteristic.
// RQ12 - Short enter press shows both output states for two seconds.
// RQ13 - Status shows both off, both on, only 1 on, or only 2 on.
// RQ14 - GE static turns off below preset minus hysteresis; LE mirrored.
// RQ15 - Comparisons use signed display value over full signed range.
module pso_preset_outputs #(
   parameter VAL_W       = 24,
   parameter PULSE_MS    = `PSO_PULSE_MS,
   parameter STATUS_MS   = `PSO_STATUS_MS,
   parameter CLK_HZ      = `PSO_CLK_HZ,
   parameter PULSE_CYC   = (CLK_HZ / 1000) * PULSE_MS,
   parameter STATUS_CYC  = (CLK_HZ / 1000) * STATUS_MS
) (
   // Clock and reset
   input  wire                     mclk,
   input  wire                     rst,
   // Register port
   input  wire [`PSO_ADDR_W-1:0]   reg_addr,
   input  wire [31:0]              reg_wdata,
   input  wire                     reg_wr,
   input  wire                     reg_rd,
   output reg  [31:0]              reg_rdata,
   // Scaled display value from the counter core
   input  wire signed [VAL_W-1:0]  display_value,
   // Enter key short press, one cycle
   input  wire                     enter_tap,
   // Counter control back to the core
   output reg                      count_clear_r,
   output reg                      count_load_r,
   output reg  signed [VAL_W-1:0]  count_load_value_r,
   // Switching outputs
   output wire                     out1,
   output wire                     out2,
   // Status display
   output reg                      status_show_r,
   output reg  [1:0]               status_ind_r
);

   // ---------------------------------------------------------------
   // Configuration registers
   // ---------------------------------------------------------------
   reg signed [VAL_W-1:0]       preset1_r;
   reg signed [VAL_W-1:0]       preset2_r;
   reg        [VAL_W-2:0]       hyst1_r;
   reg        [VAL_W-2:0]       hyst2_r;
   reg        [`PSO_CHAR_W-1:0] char1_r;
   reg        [`PSO_CHAR_W-1:0] char2_r;
   reg        [`PSO_OPMODE_W-1:0] opmode_r;

   // Level state and edge history
   reg                          lvl1_r;
   reg                          lvl2_r;
   reg                          ge1_d_r;
   reg                          le1_d_r;
   reg                          ge2_d_r;
   reg                          le2_d_r;
   reg                          zero_d_r;
   reg [31:0]                   show_cnt_r;

   wire                         pulse1;
   wire                         pulse2;
   reg                          fire1;
   reg                          fire2;
   reg                          lvl1_nxt;
   reg                          lvl2_nxt;

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   // Widen by one bit so sums near the range edges cannot wrap
   function signed [VAL_W:0] sx;
      input signed [VAL_W-1:0] v;
      begin
         sx = {v[VAL_W-1], v};
      end
   endfunction

   // Hysteresis counts only in tachometer and time modes
   function hyst_on;
      input [`PSO_OPMODE_W-1:0] m;
      begin
         hyst_on = (m == `PSO_TACHOMETER_MODE) || (m == `PSO_TIME_MODE); // RQ10
      end
   endfunction

   // Static level with hysteresis: GE holds until below p-h, LE until above p+h
   function lvl_hyst;
      input                     prev;
      input                     ge;
      input signed [VAL_W:0]    v;
      input signed [VAL_W:0]    p;
      input        [VAL_W-2:0]  h;
      reg   signed [VAL_W+1:0]  lo;
      reg   signed [VAL_W+1:0]  hi;
      begin
         lo = {p[VAL_W], p} - {3'h0, h};
         hi = {p[VAL_W], p} + {3'h0, h};
         if (ge)
            // Concatenation is unsigned; recast so negative values compare correctly
            lvl_hyst = (v >= p) || (prev && ($signed({v[VAL_W], v}) >= lo)); // RQ11 RQ14
         else
            lvl_hyst = (v <= p) || (prev && ($signed({v[VAL_W], v}) <= hi)); // RQ11 RQ14
      end
   endfunction

   // ---------------------------------------------------------------
   // Comparisons on the signed display value
   // ---------------------------------------------------------------
   wire signed [VAL_W:0] val_x  = sx(display_value); // RQ15
   wire signed [VAL_W:0] p1_x   = sx(preset1_r);
   wire signed [VAL_W:0] p2_x   = sx(preset2_r);
   // Trailing threshold recomputed every cycle from the live presets
   wire signed [VAL_W:0] antic  = p1_x - p2_x; // RQ9
   wire                  ge1    = val_x >= p1_x; // RQ15
   wire                  le1    = val_x <= p1_x;
   wire                  ge2    = val_x >= p2_x;
   wire                  le2    = val_x <= p2_x;
   wire                  gea    = val_x >= antic;
   wire                  at0    = display_value == {VAL_W{1'b0}};
   wire                  hy     = hyst_on(opmode_r);
   wire [VAL_W-2:0]      h1     = hy ? hyst1_r : {(VAL_W-1){1'b0}}; // RQ10
   wire [VAL_W-2:0]      h2     = hy ? hyst2_r : {(VAL_W-1){1'b0}}; // RQ10
   reg                   gea_d_r;

   // ---------------------------------------------------------------
   // Next level and pulse triggers per characteristic
   // ---------------------------------------------------------------
   always @* begin
      lvl1_nxt = 1'b0;
      lvl2_nxt = 1'b0;
      fire1    = 1'b0;
      fire2    = 1'b0;
      case (char1_r)
         `PSO_STATIC_GE: lvl1_nxt = lvl_hyst(lvl1_r, 1'b1, val_x, p1_x, h1); // RQ1
         `PSO_STATIC_LE: lvl1_nxt = lvl_hyst(lvl1_r, 1'b0, val_x, p1_x, h1); // RQ2
         `PSO_PULSE_GE:  fire1 = ge1 && !ge1_d_r; // RQ3
         `PSO_PULSE_LE:  fire1 = le1 && !le1_d_r; // RQ3
         `PSO_PULSE_AUTO_CLEAR: fire1 = ge1 && !ge1_d_r; // RQ4
         `PSO_PULSE_AUTO_LOAD:  fire1 = at0 && !zero_d_r; // RQ5
         default: lvl1_nxt = 1'b0;
      endcase
      case (char2_r)
         `PSO_STATIC_GE: lvl2_nxt = lvl_hyst(lvl2_r, 1'b1, val_x, p2_x, h2); // RQ1
         `PSO_STATIC_LE: lvl2_nxt = lvl_hyst(lvl2_r, 1'b0, val_x, p2_x, h2); // RQ2
         `PSO_PULSE_GE:  fire2 = ge2 && !ge2_d_r; // RQ3
         `PSO_PULSE_LE:  fire2 = le2 && !le2_d_r; // RQ3
         `PSO_ANTIC_STATIC: lvl2_nxt = gea; // RQ6
         `PSO_ANTIC_PULSE:  fire2 = gea && !gea_d_r; // RQ7
         default: lvl2_nxt = 1'b0;
      endcase
   end

   // ---------------------------------------------------------------
   // Fixed-length pulse generators, length not reachable by software
   // ---------------------------------------------------------------
   pso_pulse_timer #(
      .CYCLES (PULSE_CYC),
      .CNT_W  (32)
   ) u_pulse1 (
      .mclk    (mclk),
      .rst     (rst),
      .fire    (fire1),
      .pulse_r (pulse1)
   ); // RQ8

   pso_pulse_timer #(
      .CYCLES (PULSE_CYC),
      .CNT_W  (32)
   ) u_pulse2 (
      .mclk    (mclk),
      .rst     (rst),
      .fire    (fire2),
      .pulse_r (pulse2)
   ); // RQ8

   assign out1 = lvl1_r | pulse1;
   assign out2 = lvl2_r | pulse2;

   // ---------------------------------------------------------------
   // Level state, edge history and counter commands
   // ---------------------------------------------------------------
   always @(posedge mclk) begin
      if (rst) begin
         lvl1_r             <= 1'b0;
         lvl2_r             <= 1'b0;
         ge1_d_r            <= 1'b1;
         le1_d_r            <= 1'b1;
         ge2_d_r            <= 1'b1;
         le2_d_r            <= 1'b1;
         gea_d_r            <= 1'b1;
         zero_d_r           <= 1'b1;
         count_clear_r      <= 1'b0;
         count_load_r       <= 1'b0;
         count_load_value_r <= {VAL_W{1'b0}};
      end else begin
         lvl1_r        <= lvl1_nxt;
         lvl2_r        <= lvl2_nxt;
         ge1_d_r       <= ge1;
         le1_d_r       <= le1;
         ge2_d_r       <= ge2;
         le2_d_r       <= le2;
         gea_d_r       <= gea;
         zero_d_r      <= at0;
         // One-cycle command; the core answers by changing display_value
         count_clear_r <= fire1 && (char1_r == `PSO_PULSE_AUTO_CLEAR); // RQ4
         count_load_r  <= fire1 && (char1_r == `PSO_PULSE_AUTO_LOAD); // RQ5
         count_load_value_r <= preset1_r; // RQ5
      end
   end

   // ---------------------------------------------------------------
   // Status display window after a short enter press
   // ---------------------------------------------------------------
   always @(posedge mclk) begin
      if (rst) begin
         show_cnt_r    <= 32'h0000_0000;
         status_show_r <= 1'b0;
         status_ind_r  <= `PSO_IND_BOTH_OFF;
      end else begin
         if (enter_tap) begin
            show_cnt_r    <= STATUS_CYC[31:0] - 32'h0000_0001; // RQ12
            status_show_r <= 1'b1;
         end else if (show_cnt_r != 32'h0000_0000) begin
            show_cnt_r <= show_cnt_r - 32'h0000_0001;
         end else begin
            status_show_r <= 1'b0; // RQ12
         end
         // Live state so the indication tracks the outputs while shown
         case ({out1, out2})
            2'b00:   status_ind_r <= `PSO_IND_BOTH_OFF; // RQ13
            2'b11:   status_ind_r <= `PSO_IND_BOTH_ON; // RQ13
            2'b10:   status_ind_r <= `PSO_IND_OUT1_ON; // RQ13
            default: status_ind_r <= `PSO_IND_OUT2_ON; // RQ13
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Register writes
   // ---------------------------------------------------------------
   always @(posedge mclk) begin
      if (rst) begin
         preset1_r <= {VAL_W{1'b0}};
         preset2_r <= {VAL_W{1'b0}};
         hyst1_r   <= {(VAL_W-1){1'b0}};
         hyst2_r   <= {(VAL_W-1){1'b0}};
         char1_r   <= `PSO_STATIC_GE;
         char2_r   <= `PSO_STATIC_GE;
         opmode_r  <= `PSO_COUNT_MODE;
      end else if (reg_wr) begin
         case (reg_addr)
            `PSO_REG_PRESET1: preset1_r <= reg_wdata[VAL_W-1:0];
            `PSO_REG_PRESET2: preset2_r <= reg_wdata[VAL_W-1:0];
            `PSO_REG_HYST1:   hyst1_r   <= reg_wdata[VAL_W-2:0];
            `PSO_REG_HYST2:   hyst2_r   <= reg_wdata[VAL_W-2:0];
            `PSO_REG_CTRL: begin
               char1_r  <= reg_wdata[`PSO_CTRL_CHAR1_LSB +: `PSO_CHAR_W];
               char2_r  <= reg_wdata[`PSO_CTRL_CHAR2_LSB +: `PSO_CHAR_W];
               opmode_r <= reg_wdata[`PSO_CTRL_OPMODE_LSB +: `PSO_OPMODE_W];
            end
            default: preset1_r <= preset1_r;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Register reads, data one cycle after the strobe, zero otherwise
   // ---------------------------------------------------------------
   always @(posedge mclk) begin
      if (rst) begin
         reg_rdata <= 32'h0000_0000;
      end else if (reg_rd) begin
         case (reg_addr)
            `PSO_REG_PRESET1: reg_rdata <= {{(32-VAL_W){preset1_r[VAL_W-1]}}, preset1_r};
            `PSO_REG_PRESET2: reg_rdata <= {{(32-VAL_W){preset2_r[VAL_W-1]}}, preset2_r};
            `PSO_REG_HYST1:   reg_rdata <= {{(33-VAL_W){1'b0}}, hyst1_r};
            `PSO_REG_HYST2:   reg_rdata <= {{(33-VAL_W){1'b0}}, hyst2_r};
            `PSO_REG_CTRL:    reg_rdata <= {21'h0, opmode_r, 1'b0, char2_r, 1'b0, char1_r};
            `PSO_REG_STATUS:  reg_rdata <= {27'h0, status_show_r, status_ind_r, out2, out1};
            `PSO_REG_DISPLAY: reg_rdata <= {{(32-VAL_W){display_value[VAL_W-1]}},
                                            display_value};
            default:          reg_rdata <= 32'h0000_0000;
         endcase
      end else begin
         reg_rdata <= 32'h0000_0000;
      end
   end

endmodule

// *** rtl/pso_regs.vh ***
// Register map, field codes and timing constants of the preset switching outputs
`ifndef PSO_REGS_VH
`define PSO_REGS_VH

// ---------------------------------------------------------------
// Register offsets (word index on the plain register port)
// ---------------------------------------------------------------
`define PSO_ADDR_W        4
`define PSO_REG_PRESET1   4'h0
`define PSO_REG_PRESET2   4'h1
`define PSO_REG_HYST1     4'h2
`define PSO_REG_HYST2     4'h3
`define PSO_REG_CTRL      4'h4
`define PSO_REG_STATUS    4'h5
`define PSO_REG_DISPLAY   4'h6

// ---------------------------------------------------------------
// Control register fields
// ---------------------------------------------------------------
`define PSO_CTRL_CHAR1_LSB 0
`define PSO_CTRL_CHAR2_LSB 4
`define PSO_CTRL_OPMODE_LSB 8
`define PSO_CTRL_RESET     32'h0000_0000

// Characteristic codes
`define PSO_CHAR_W         3
`define PSO_STATIC_GE      3'h0
`define PSO_STATIC_LE      3'h1
`define PSO_PULSE_GE       3'h2
`define PSO_PULSE_LE       3'h3
`define PSO_PULSE_AUTO_CLEAR 3'h4
`define PSO_PULSE_AUTO_LOAD  3'h5
`define PSO_ANTIC_STATIC   3'h4
`define PSO_ANTIC_PULSE    3'h5

// Operating modes
`define PSO_OPMODE_W       3
`define PSO_TACHOMETER_MODE 3'h0
`define PSO_TIME_MODE      3'h1
`define PSO_TIMER_MODE     3'h2
`define PSO_COUNT_MODE     3'h3
`define PSO_SPEED_DIFF_MODE 3'h4

// Status display indications
`define PSO_IND_BOTH_OFF   2'h0
`define PSO_IND_BOTH_ON    2'h1
`define PSO_IND_OUT1_ON    2'h2
`define PSO_IND_OUT2_ON    2'h3

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define PSO_CLK_HZ         100000000
`define PSO_PULSE_MS       500
`define PSO_STATUS_MS      2000

`endif

// *** rtl/pso_pulse_timer.v ***
// One-shot timer for a fixed-length output pulse
`timescale 1ns/1ps

module pso_pulse_timer #(
   parameter CYCLES = 50000000,
   parameter CNT_W  = 26
) (
   // Clock and reset
   input  wire mclk,
   input  wire rst,
   // Trigger and pulse
   input  wire fire,
   output reg  pulse_r
);

   reg [CNT_W-1:0] cnt_r;

   // ---------------------------------------------------------------
   // Countdown; a new trigger while busy restarts the full length
   // ---------------------------------------------------------------
   always @(posedge mclk) begin
      if (rst) begin
         cnt_r   <= {CNT_W{1'b0}};
         pulse_r <= 1'b0;
      end else if (fire) begin
         cnt_r   <= CYCLES[CNT_W-1:0] - {{(CNT_W-1){1'b0}}, 1'b1};
         pulse_r <= 1'b1;
      end else if (cnt_r != {CNT_W{1'b0}}) begin
         cnt_r <= cnt_r - {{(CNT_W-1){1'b0}}, 1'b1};
      end else begin
         pulse_r <= 1'b0;
      end
   end

endmodule

// *** verification/pso_core_model.sv ***
// Counter core model that feeds the display value and obeys clear and load requests
`timescale 1ns/1ps
// ------------------------------------------------
// Counter core model
// ------------------------------------------------
module pso_core_model #(
   parameter VAL_W = 24
) (
   // Clock and reset
   input  wire                    mclk,
   input  wire                    rst,
   // Requests from the switching outputs
   input  wire                    count_clear_r,
   input  wire                    count_load_r,
   input  wire signed [VAL_W-1:0] count_load_value_r,
   // Bench positioning of the count
   input  wire                    set_en,
   input  wire signed [VAL_W-1:0] set_value,
   // Count shown on the display
   output reg  signed [VAL_W-1:0] display_value
);
   // Requests act one edge late, as a real core would
   always @(posedge mclk) begin
      if (rst)
         display_value <= {VAL_W{1'b0}};
      else if (set_en)
         display_value <= set_value;
      else if (count_clear_r)
         display_value <= {VAL_W{1'b0}};
      else if (count_load_r)
         display_value <= count_load_value_r;
   end
endmodule

// *** verification/pso_preset_outputs_properties.sv ***
// Port timing checker for the preset switching outputs
`timescale 1ns/1ps
`include "pso_regs.vh"
// ------------------------------------------------
// Checker
// ------------------------------------------------
module pso_props #(
   parameter VAL_W      = 24,
   parameter PULSE_CYC  = 8,
   parameter STATUS_CYC = 20
) (
   // Clock and reset
   input  wire                    mclk,
   input  wire                    rst,
   // Register port
   input  wire [`PSO_ADDR_W-1:0]  reg_addr,
   input  wire [31:0]             reg_wdata,
   input  wire                    reg_wr,
   input  wire                    reg_rd,
   input  wire [31:0]             reg_rdata,
   // Value, key and counter control
   input  wire signed [VAL_W-1:0] display_value,
   input  wire                    enter_tap,
   input  wire                    count_clear_r,
   input  wire                    count_load_r,
   input  wire signed [VAL_W-1:0] count_load_value_r,
   // Outputs and status
   input  wire                    out1,
   input  wire                    out2,
   input  wire                    status_show_r,
   input  wire [1:0]              status_ind_r
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   reg [31:0] sc_r;
   // Cycles since the last tap; saturates so a long idle never wraps
   always @(posedge mclk) begin
      if (rst)
         sc_r <= 32'h0;
      else if (enter_tap)
         sc_r <= 32'h1;
      else if (sc_r != 32'h0 && sc_r <= STATUS_CYC)
         sc_r <= sc_r + 32'h1;
   end
   function [1:0] ind(input a, input b);
      ind = (a & b) ? 2'h1 : a ? 2'h2 : b ? 2'h3 : 2'h0;
   endfunction
   property p_ind; status_ind_r == ind($past(out1), $past(out2)); endproperty
   property p_show_len; status_show_r == (sc_r != 32'h0 && sc_r <= STATUS_CYC); endproperty
   property p_show_cause; $rose(status_show_r) |-> $past(enter_tap); endproperty
   property p_clr_once; count_clear_r |=> !count_clear_r; endproperty
   property p_clr_pulse; count_clear_r |-> out1 [*8]; endproperty
   property p_load_zero; count_load_r |-> $past(display_value) == 0; endproperty
   property p_load_pulse; count_load_r |-> out1 [*8]; endproperty
   property p_load_once; count_load_r |=> !count_load_r ##1 !count_load_r; endproperty
   a_ind: assert property (p_ind) else $error("status indication wrong");
   a_show_len: assert property (p_show_len) else $error("status show length wrong");
   a_show_cause: assert property (p_show_cause) else $error("status show without tap");
   a_clr_once: assert property (p_clr_once) else $error("clear request too long");
   a_clr_pulse: assert property (p_clr_pulse) else $error("clear pulse short");
   a_load_zero: assert property (p_load_zero) else $error("load not at zero");
   a_load_pulse: assert property (p_load_pulse) else $error("load pulse short");
   a_load_once: assert property (p_load_once) else $error("load request repeated");
   c_clr: cover property (count_clear_r);
   c_load: cover property (count_load_r);
   c_show: cover property ($fell(status_show_r));
endmodule
bind pso_preset_outputs pso_props #(
   .VAL_W(VAL_W), .PULSE_CYC(PULSE_CYC), .STATUS_CYC(STATUS_CYC)
) u_pso_props (
   .mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
   .reg_rd(reg_rd), .reg_rdata(reg_rdata), .display_value(display_value),
   .enter_tap(enter_tap), .count_clear_r(count_clear_r), .count_load_r(count_load_r),
   .count_load_value_r(count_load_value_r), .out1(out1), .out2(out2),
   .status_show_r(status_show_r), .status_ind_r(status_ind_r)
);

// *** verification/pso_preset_outputs_bench.sv ***
// Self-checking bench for the preset switching outputs
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin num_errors++; \
   $display("ERROR %0t got %h expected %h", $time, (a), (b)); end end
// ------------------------------------------------
// Bench top
// ------------------------------------------------
module pso_preset_outputs_bench;
   logic mclk = 0, rst = 1, reg_wr = 0, reg_rd = 0, enter_tap = 0, set_en = 0;
   logic [3:0] reg_addr = 0;
   logic [31:0] reg_wdata = 0;
   logic signed [23:0] set_value = 0;
   wire [31:0] reg_rdata;
   wire signed [23:0] disp, ld_val;
   wire clr, ld, out1, out2, show;
   wire [1:0] ind;
   integer num_errors = 0, compares = 0;
   // Short pulse and status counts keep the run brief
   pso_preset_outputs #(.PULSE_CYC(8), .STATUS_CYC(20)) u_pso_preset_outputs (
      .mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .display_value(disp),
      .enter_tap(enter_tap), .count_clear_r(clr), .count_load_r(ld),
      .count_load_value_r(ld_val), .out1(out1), .out2(out2),
      .status_show_r(show), .status_ind_r(ind));
   pso_core_model u_pso_core_model (
      .mclk(mclk), .rst(rst), .count_clear_r(clr), .count_load_r(ld),
      .count_load_value_r(ld_val), .set_en(set_en), .set_value(set_value),
      .display_value(disp));
   initial begin
      forever #5 mclk = ~mclk;
   end
   task wr(input [3:0] a, input [31:0] d);
      @(posedge mclk);
      reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
      @(posedge mclk);
      reg_wr <= 1'b0;
      // Let the new setting reach the outputs
      repeat (2) @(posedge mclk);
      #1;
   endtask
   task rd(input [3:0] a, input [31:0] e);
      @(posedge mclk);
      reg_rd <= 1'b1; reg_addr <= a;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1;
      `CHK(reg_rdata, e)
   endtask
   task mode(input [2:0] c1, input [2:0] c2, input [2:0] m);
      wr(4'h4, {21'h0, m, 1'b0, c2, 1'b0, c1});
   endtask
   // Value lands one edge later, outputs one edge after that
   task setv(input integer v);
      @(posedge mclk);
      set_en <= 1'b1; set_value <= v[23:0];
      @(posedge mclk);
      set_en <= 1'b0;
      @(posedge mclk);
      #1;
   endtask
   // Bounded count of high cycles of a chosen output
   task plen(input [1:0] s, input integer e);
      integer n;
      n = 0;
      while ((s == 0 ? out1 : s == 1 ? out2 : show) === 1'b1 && n < 100) begin
         n = n + 1;
         @(posedge mclk);
         #1;
      end
      `CHK(n, e)
   endtask
   task s_regs;
      rd(4'h0, 32'h0);
      wr(4'h0, 32'h00ff_ff9c);
      rd(4'h0, 32'hffff_ff9c);
      rd(4'hf, 32'h0);
   endtask
   task s_static;
      mode(0, 1, 3); wr(4'h0, 100); wr(4'h1, 50);
      setv(99);  `CHK(out1, 1'b0)
      setv(100); `CHK(out1, 1'b1)
      setv(50);  `CHK({out1, out2}, 2'b01)
      setv(-5);  `CHK(out2, 1'b1)
      rd(4'h5, 32'he);
   endtask
   task s_hyst;
      wr(4'h2, 10); wr(4'h3, 10); mode(0, 1, 0);
      setv(100); setv(95); `CHK(out1, 1'b1)
      setv(89);  `CHK(out1, 1'b0)
      setv(50);  setv(55); `CHK(out2, 1'b1)
      setv(61);  `CHK(out2, 1'b0)
      mode(0, 1, 3); setv(100); setv(95); `CHK(out1, 1'b0)
      mode(0, 1, 1); setv(100); setv(95); `CHK(out1, 1'b1)
   endtask
   task s_pulse;
      wr(4'h1, 0); mode(2, 3, 3);
      setv(100); plen(0, 8);
      setv(0);   plen(1, 8);
   endtask
   task s_auto;
      mode(4, 6, 3); setv(100); `CHK(clr, 1'b1)
      plen(0, 8); `CHK(disp, 24'sd0)
      setv(5); mode(5, 6, 3); setv(0); `CHK(ld, 1'b1)
      plen(0, 8); `CHK(disp, 24'sd100)
   endtask
   task s_antic;
      wr(4'h1, 30); mode(6, 4, 3);
      setv(69); `CHK(out2, 1'b0)
      setv(70); `CHK(out2, 1'b1)
      wr(4'h0, 120); `CHK(out2, 1'b0)
      mode(6, 5, 3); setv(89); setv(90); plen(1, 8);
   endtask
   task s_status;
      mode(0, 6, 3); setv(200);
      @(posedge mclk);
      enter_tap <= 1'b1;
      @(posedge mclk);
      enter_tap <= 1'b0;
      #1;
      `CHK(ind, 2'h2)
      plen(2, 20);
      mode(0, 0, 3); @(posedge mclk); #1; `CHK(ind, 2'h1)
      setv(-10); @(posedge mclk); #1; `CHK(ind, 2'h0)
   endtask
   task summarize;
      $display("Compares %0d, errors %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // Watchdog against a hang
   initial begin
      #500000;
      num_errors++;
      summarize;
   end
   initial begin
      repeat (10) @(posedge mclk);
      rst <= 1'b0;
      s_regs; s_static; s_hyst; s_pulse; s_auto; s_antic; s_status;
      summarize;
   end
endmodule
